// ==== vrs_ctrl_top.sv ====
// Control core: internal registers, interrupt and power controls
`timescale 1ns/1ps
`default_nettype none
module vrs_ctrl_top (
   input  wire logic          mclk,
   input  wire logic          rstn,
   input  wire logic          ce,
   input  wire logic          sclk,
   input  wire logic          mosi,
   input  wire logic          ssN,
   input  wire logic          ovfEvent,
   input  wire logic          eomEvent,
   output var  logic          misoOut,
   output var  logic          misoOe,
   output var  logic          intOutN,
   output var  logic          intOe,
   output var  logic [1:0]    rateSel,
   output var  logic [1:0]    bandSel,
   output var  logic [3:0]    durationMin,
   output var  logic [10:0]   rowAddr,
   output var  logic [7:0]    stagePwrDown
);
   import vrs_pkg::*;

   vrs_link_if link ();
   vrs_core_t  st_reg;
   vrs_core_t  st_next;
   logic [2:0] wrAddr;
   logic       wrCmd;
   logic [15:0] wrData;
   logic       frameEnd;
   logic [15:0] statusWord;

   ////////////////////////////////////////////////////////////////////////
   // Duration in minutes for a rate code
   function automatic logic [3:0] durationOf(input vrs_rate_t r);
      logic [3:0] d;
      d = DUR_8K0;
      unique case (r)
         VRS_RATE_8K0: d = DUR_8K0;
         VRS_RATE_6K4: d = DUR_6K4;
         VRS_RATE_5K3: d = DUR_5K3;
         VRS_RATE_4K0: d = DUR_4K0;
      endcase
      return d;
   endfunction : durationOf

   // Read value of a register index
   function automatic logic [15:0] readReg(input logic [2:0] a,
                                           input vrs_core_t s);
      logic [15:0] v;
      v = 16'h0000;
      unique case (a)
         REG_CFG:    v = {5'h00, s.cfg};
         REG_ROW:    v = {5'h00, s.row};
         REG_STATUS: v = {10'h000, s.rate, s.rowErr, s.intOe,
                          s.eomFlag, s.ovfFlag};
         default:    v = 16'h0000;
      endcase
      return v;
   endfunction : readReg

   ////////////////////////////////////////////////////////////////////////
   // Serial shifter
   vrs_spi_shift u_shift (
      .mclk (mclk),
      .rstn (rstn),
      .ce   (ce),
      .sclk (sclk),
      .mosi (mosi),
      .ssN  (ssN),
      .link (link.shifter)
   );

   // Outgoing word: selected register above status byte
   assign statusWord  = readReg(REG_STATUS, st_reg);
   assign link.txWord = {readReg(st_reg.readSel, st_reg),
                         statusWord[7:0]};

   // Decoded command fields
   assign wrAddr   = link.rxWord[ADDR_MSB:ADDR_LSB];
   assign wrCmd    = link.rxWord[WR_BIT];
   assign wrData   = link.rxWord[DATA_MSB:DATA_LSB];
   assign frameEnd = link.frameDone & link.frameOk;

   ////////////////////////////////////////////////////////////////////////
   // Next state of the core
   always_comb
   begin
      st_next         = st_reg;
      // Data output follows the shifter only while selected
      st_next.misoOe  = link.selected;
      st_next.misoOut = link.selected ? link.txBit : 1'b0;
      // Commands act only once a complete frame has ended
      if (frameEnd)
      begin
         if (!wrCmd)
            st_next.readSel = wrAddr;
         else if (wrAddr == REG_CFG)
            st_next.cfg = wrData[CFG_W-1:0];
         else if (wrAddr == REG_ROW)
         begin
            if (wrData[ROW_W-1:0] < ROW_COUNT)
            begin
               st_next.row    = wrData[ROW_W-1:0];
               st_next.rowErr = 1'b0;
            end
            else
               st_next.rowErr = 1'b1;
         end
      end
      // Sticky flags: a new event beats the clear from a frame end
      st_next.ovfFlag = (st_reg.ovfFlag & ~frameEnd) | ovfEvent;
      st_next.eomFlag = (st_reg.eomFlag & ~frameEnd) | eomEvent;
      st_next.intOe   = st_next.ovfFlag | st_next.eomFlag;
      st_next.intOut  = 1'b0;
      // Rate, filter band and duration follow the rate field
      st_next.rate    = vrs_rate_t'(st_next.cfg[CFG_RATE_LSB +: 2]);
      st_next.durMin  = durationOf(st_next.rate);
      // Stage power-downs, master bit forces all off
      st_next.pwrDown = st_next.cfg[CFG_PD_LSB +: PD_W]
                        | {PD_W{st_next.cfg[CFG_PD_ALL]}};
   end

   // State register
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_reg <= '{intOut: 1'b0, intOe: 1'b0, misoOut: 1'b0,
                     misoOe: 1'b0, ovfFlag: 1'b0, eomFlag: 1'b0,
                     rowErr: 1'b0, cfg: CFG_RESET, row: ROW_RESET,
                     readSel: REG_STATUS, pwrDown: 8'h00,
                     rate: VRS_RATE_8K0, durMin: DUR_8K0};
      end
      else if (ce)
      begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs straight from the state register
   assign misoOut      = st_reg.misoOut;
   assign misoOe       = st_reg.misoOe;
   assign intOutN      = st_reg.intOut;
   assign intOe        = st_reg.intOe;
   assign rateSel      = st_reg.rate;
   assign bandSel      = st_reg.rate;
   assign durationMin  = st_reg.durMin;
   assign rowAddr      = st_reg.row;
   assign stagePwrDown = st_reg.pwrDown;
endmodule : vrs_ctrl_top
`default_nettype wire

// ==== vrs_pkg.sv ====
// Package of constants and types for the voice recorder serial control port
// Overview of operation
// - Four selectable sample rates set duration
// - Slower rate narrows filter pass band
// - Any of 1200 rows is addressable
// - Slave only on four-wire serial bus
// - Registers reached only through serial port
// - Active-low interrupt plus read-only status
// - Capture on rising, shift out falling
// - Select low selects; high ignores bus
// - Control register governs overall power
// - Each stage has its own power-down
// - Data set early, words LSB first
// - Data output driven only while selected
// - Interrupt held low until next transaction; the code clears it only when a full 24-bit frame ends
package vrs_pkg;
   ////////////////////////////////////////////////////////////////////////
   // Frame layout, least significant bit first on the wire
   localparam int           FRAME_BITS   = 24;
   localparam int           CNT_W        = 5;
   localparam logic [4:0]   FRAME_LEN    = 5'h18;
   localparam logic [4:0]   CNT_MAX      = 5'h1F;
   localparam int           ADDR_LSB     = 0;
   localparam int           ADDR_MSB     = 2;
   localparam int           WR_BIT       = 3;
   localparam int           DATA_LSB     = 8;
   localparam int           DATA_MSB     = 23;
   ////////////////////////////////////////////////////////////////////////
   // Register indices
   localparam logic [2:0]   REG_CFG      = 3'h0;
   localparam logic [2:0]   REG_ROW      = 3'h1;
   localparam logic [2:0]   REG_STATUS   = 3'h2;
   // Configuration fields
   localparam int           CFG_W        = 11;
   localparam int           CFG_RATE_LSB = 0;
   localparam int           CFG_PD_LSB   = 2;
   localparam int           CFG_PD_ALL   = 10;
   localparam int           PD_W         = 8;
   localparam logic [10:0]  CFG_RESET    = 11'h000;
   // Row address
   localparam int           ROW_W        = 11;
   localparam logic [10:0]  ROW_COUNT    = 11'h4B0;
   localparam logic [10:0]  ROW_RESET    = 11'h000;
   ////////////////////////////////////////////////////////////////////////
   // Sample rate codes; filter pass band tracks the same code
   typedef enum logic [1:0] {
      VRS_RATE_8K0 = 2'h0,
      VRS_RATE_6K4 = 2'h1,
      VRS_RATE_5K3 = 2'h2,
      VRS_RATE_4K0 = 2'h3
   } vrs_rate_t;
   // Durations in minutes
   localparam logic [3:0]   DUR_8K0      = 4'h4;
   localparam logic [3:0]   DUR_6K4      = 4'h5;
   localparam logic [3:0]   DUR_5K3      = 4'h6;
   localparam logic [3:0]   DUR_4K0      = 4'h8;
   ////////////////////////////////////////////////////////////////////////
   // State of the serial shifter
   typedef struct packed {
      logic [1:0]       sclkSync;
      logic [1:0]       mosiSync;
      logic [1:0]       ssnSync;
      logic             sclkDly;
      logic             ssnDly;
      logic [4:0]       bitCnt;
      logic [23:0]      rxShift;
      logic [23:0]      txShift;
      logic             start;
      logic             done;
      logic             ok;
   } vrs_shift_t;
   // State of the control core
   typedef struct packed {
      logic             intOut;
      logic             intOe;
      logic             misoOut;
      logic             misoOe;
      logic             ovfFlag;
      logic             eomFlag;
      logic             rowErr;
      logic [10:0]      cfg;
      logic [10:0]      row;
      logic [2:0]       readSel;
      logic [7:0]       pwrDown;
      vrs_rate_t        rate;
      logic [3:0]       durMin;
   } vrs_core_t;
endpackage : vrs_pkg

// ==== vrs_link_if.sv ====
// Interface between the serial shifter and the control core
`timescale 1ns/1ps
`default_nettype none
interface vrs_link_if;
   logic          frameStart;
   logic          frameDone;
   logic          frameOk;
   logic          selected;
   logic          txBit;
   logic [23:0]   rxWord;
   logic [23:0]   txWord;
   modport shifter (
      output frameStart,
      output frameDone,
      output frameOk,
      output selected,
      output txBit,
      output rxWord,
      input  txWord
   );
   modport core (
      input  frameStart,
      input  frameDone,
      input  frameOk,
      input  selected,
      input  txBit,
      input  rxWord,
      output txWord
   );
endinterface : vrs_link_if
`default_nettype wire

// ==== vrs_spi_shift.sv ====
// Serial shifter: synchronises the bus pins and moves frame bits
`timescale 1ns/1ps
`default_nettype none
module vrs_spi_shift (
   input  wire logic    mclk,
   input  wire logic    rstn,
   input  wire logic    ce,
   input  wire logic    sclk,
   input  wire logic    mosi,
   input  wire logic    ssN,
   vrs_link_if.shifter  link
);
   import vrs_pkg::*;

   vrs_shift_t st_reg;
   vrs_shift_t st_next;
   logic       sclkRise;
   logic       sclkFall;
   logic       sel;

   ////////////////////////////////////////////////////////////////////////
   // Edge finding on the second synchroniser stages only
   assign sclkRise = st_reg.sclkSync[1] & ~st_reg.sclkDly;
   assign sclkFall = ~st_reg.sclkSync[1] & st_reg.sclkDly;
   assign sel      = ~st_reg.ssnSync[1];

   // Next state of the shifter
   always_comb
   begin
      st_next             = st_reg;
      st_next.sclkSync    = {st_reg.sclkSync[0], sclk};
      st_next.mosiSync    = {st_reg.mosiSync[0], mosi};
      st_next.ssnSync     = {st_reg.ssnSync[0], ssN};
      st_next.sclkDly     = st_reg.sclkSync[1];
      st_next.ssnDly      = st_reg.ssnSync[1];
      st_next.start       = 1'b0;
      st_next.done        = 1'b0;
      st_next.ok          = 1'b0;
      if (sel && st_reg.ssnDly)
      begin
         // Select just fell: load outgoing word, restart count
         st_next.start    = 1'b1;
         st_next.bitCnt   = '0;
         st_next.txShift  = link.txWord;
      end
      else if (sel)
      begin
         if (sclkRise)
         begin
            st_next.rxShift = {st_reg.mosiSync[1], st_reg.rxShift[23:1]};
            if (st_reg.bitCnt != CNT_MAX)
               st_next.bitCnt = st_reg.bitCnt + 5'h01;
         end
         if (sclkFall && st_reg.bitCnt != 5'h00)
            st_next.txShift = {1'b0, st_reg.txShift[23:1]};
      end
      else if (st_reg.ssnSync[1] && !st_reg.ssnDly)
      begin
         // Select rose: frame over
         st_next.done     = 1'b1;
         st_next.ok       = (st_reg.bitCnt == FRAME_LEN);
      end
   end

   // State register
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_reg <= '{sclkSync: 2'h0, mosiSync: 2'h0, ssnSync: 2'h3,
                     sclkDly: 1'b0, ssnDly: 1'b1, bitCnt: 5'h00,
                     rxShift: 24'h000000, txShift: 24'h000000,
                     start: 1'b0, done: 1'b0, ok: 1'b0};
      end
      else if (ce)
      begin
         st_reg <= st_next;
      end
   end

   // Results toward the core
   assign link.frameStart = st_reg.start;
   assign link.frameDone  = st_reg.done;
   assign link.frameOk    = st_reg.ok;
   assign link.selected   = sel;
   assign link.txBit      = st_reg.txShift[0];
   assign link.rxWord     = st_reg.rxShift;
endmodule : vrs_spi_shift
`default_nettype wire

// ==== vrs_ctrl_monitor.sv ====
// Assertion checker for the serial control port top
`timescale 1ns/1ps
`default_nettype none
module vrs_ctrl_monitor
   import vrs_pkg::*;
(
   input wire logic        mclk,
   input wire logic        rstn,
   input wire logic        ce,
   input wire logic        sclk,
   input wire logic        mosi,
   input wire logic        ssN,
   input wire logic        ovfEvent,
   input wire logic        eomEvent,
   input wire logic        misoOut,
   input wire logic        misoOe,
   input wire logic        intOutN,
   input wire logic        intOe,
   input wire logic [1:0]  rateSel,
   input wire logic [1:0]  bandSel,
   input wire logic [3:0]  durationMin,
   input wire logic [10:0] rowAddr,
   input wire logic [7:0]  stagePwrDown
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);
   // Select held long enough for the synchronisers to settle
   sequence s_idle;
      ssN [*7];
   endsequence
   sequence s_sel;
      !ssN [*6];
   endsequence
   ////////////////////////////////////////
   property p_band;
      bandSel == rateSel;
   endproperty
   a_band: assert property (p_band)
      else $error("band code differs from rate code");
   property p_dur;
      durationMin == ((rateSel == 2'h3) ? DUR_4K0 : DUR_8K0 + rateSel);
   endproperty
   a_dur: assert property (p_dur)
      else $error("duration does not match rate");
   property p_row;
      rowAddr < ROW_COUNT;
   endproperty
   a_row: assert property (p_row)
      else $error("row address out of range");
   property p_oeOff;
      s_idle |-> !misoOe;
   endproperty
   a_oeOff: assert property (p_oeOff)
      else $error("data out driven while deselected");
   property p_oeOn;
      s_sel |-> misoOe;
   endproperty
   a_oeOn: assert property (p_oeOn)
      else $error("data out not driven while selected");
   property p_intSet;
      (ce && (ovfEvent || eomEvent)) |-> ##2 (intOe && !intOutN);
   endproperty
   a_intSet: assert property (p_intSet)
      else $error("interrupt not raised after event");
   property p_intHold;
      (s_idle ##0 intOe) |=> intOe;
   endproperty
   a_intHold: assert property (p_intHold)
      else $error("interrupt dropped without a frame");
   property p_still;
      s_sel |=> ($stable(rateSel) && $stable(rowAddr));
   endproperty
   a_still: assert property (p_still)
      else $error("settings changed inside a frame");
   property p_txFall;
      $changed(misoOut) |-> (!sclk && !$past(sclk, 2));
   endproperty
   a_txFall: assert property (p_txFall)
      else $error("data out changed outside clock low phase");
endmodule : vrs_ctrl_monitor
bind vrs_ctrl_top vrs_ctrl_monitor i_vrs_ctrl_monitor (
   .mclk, .rstn, .ce, .sclk, .mosi, .ssN, .ovfEvent, .eomEvent,
   .misoOut, .misoOe, .intOutN, .intOe, .rateSel, .bandSel,
   .durationMin, .rowAddr, .stagePwrDown
);
`default_nettype wire

// ==== vrs_host_model.sv ====
// Host master model clocking frames over the serial link
`timescale 1ns/1ps
`default_nettype none
module vrs_host_model (
   output var  logic sclk,
   output var  logic mosi,
   output var  logic ssN,
   input  wire logic miso
);
   // Idle bus: clock low, deselected
   initial
   begin
      sclk = 1'b0;
      mosi = 1'b0;
      ssN = 1'b1;
   end
   // One frame of n bits, LSB first; sel low leaves select high
   task automatic frame(input logic [23:0] tx, input int n,
                        input logic sel, output logic [23:0] rx);
      rx = 24'h0;
      ssN = !sel;
      for (int i = 0; i < n; i++)
      begin
         mosi = tx[i];
         #80;
         sclk = 1'b1;
         rx[i] = miso;
         #80;
         sclk = 1'b0;
      end
      // Released data line shows the inverse of its last bit
      mosi = ~mosi;
      #80;
      ssN = 1'b1;
      #40;
   endtask : frame
endmodule : vrs_host_model
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the serial control port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import vrs_pkg::*;
   typedef struct packed {
      logic [2:0]  idx;
      logic [15:0] data;
      logic [1:0]  rate;
      logic [3:0]  dur;
      logic [10:0] row;
   } vrs_row_t;
   localparam vrs_row_t ROWS [7] = '{
      '{REG_CFG, 16'h0003, 2'h3, 4'h8, 11'h000},
      '{REG_CFG, 16'h03F6, 2'h2, 4'h6, 11'h000},
      '{REG_CFG, 16'h0401, 2'h1, 4'h5, 11'h000},
      '{REG_ROW, 16'h04AF, 2'h1, 4'h5, 11'h4AF},
      '{3'h3, 16'h0002, 2'h1, 4'h5, 11'h4AF},
      '{REG_CFG, 16'h0000, 2'h0, 4'h4, 11'h4AF},
      '{REG_ROW, 16'h02AA, 2'h0, 4'h4, 11'h2AA}};
   logic        mclk, rstn, ce, ovfEvent, eomEvent;
   logic        misoOut, misoOe, intOutN, intOe;
   logic [1:0]  rateSel, bandSel;
   logic [3:0]  durationMin;
   logic [10:0] rowAddr;
   logic [7:0]  stagePwrDown, pd;
   logic [23:0] rx;
   wire         sclk, mosi, ssN;
   int          failures, checkCount, cycles;
   // Pin levels: data out inverts when released, interrupt pulled up
   wire         misoPin = misoOe ? misoOut : ~misoOut;
   wire         intPin = intOe ? intOutN : 1'b1;
   vrs_ctrl_top i_vrs_ctrl_top (.mclk, .rstn, .ce, .sclk, .mosi, .ssN,
      .ovfEvent, .eomEvent, .misoOut, .misoOe, .intOutN, .intOe,
      .rateSel, .bandSel, .durationMin, .rowAddr, .stagePwrDown);
   vrs_host_model i_vrs_host_model (.sclk, .mosi, .ssN, .miso(misoPin));
   ////////////////////////////////////////
   always #2.5 mclk = ~mclk;
   // Hang guard
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         failures++;
         results();
      end
   end
   task automatic results();
      $display("Comparisons %0d mismatches %0d", checkCount, failures);
      if (failures == 0 && checkCount > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : results
   task automatic chk(input string nm, input logic [23:0] exp, got);
      checkCount++;
      if (got !== exp)
      begin
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
         failures++;
      end
   endtask : chk
   function automatic logic [23:0] cw(input logic [2:0] idx,
                                      input logic wr, logic [15:0] d);
      return {d, 4'h0, wr, idx};
   endfunction : cw
   task automatic xfer(input logic [23:0] cmd, input int n, input logic s);
      i_vrs_host_model.frame(cmd, n, s, rx);
      repeat (8) @(posedge mclk);
      #1;
   endtask : xfer
   task automatic chkState(input logic [1:0] r, input logic [3:0] d,
                           input logic [10:0] row);
      chk("rateSel", r, rateSel);
      chk("bandSel", r, bandSel);
      chk("durationMin", d, durationMin);
      chk("rowAddr", row, rowAddr);
      chk("stagePwrDown", pd, stagePwrDown);
   endtask : chkState
   ////////////////////////////////////////
   initial
   begin
      mclk = 1'b0;
      rstn = 1'b0;
      ce = 1'b1;
      ovfEvent = 1'b0;
      eomEvent = 1'b0;
      pd = 8'h00;
      repeat (4) @(posedge mclk);
      #1;
      rstn = 1'b1;
      chkState(2'h0, 4'h4, 11'h000);
      chk("misoOe", 1'b0, misoOe);
      chk("intOe", 1'b0, intOe);
      repeat (3) @(posedge mclk);
      #1;
      // Table of register writes
      foreach (ROWS[i])
      begin
         xfer(cw(ROWS[i].idx, 1'b1, ROWS[i].data), 24, 1'b1);
         if (ROWS[i].idx == REG_CFG)
            pd = ROWS[i].data[10] ? 8'hFF : ROWS[i].data[9:2];
         chkState(ROWS[i].rate, ROWS[i].dur, ROWS[i].row);
      end
      // Row 1200 is refused and flagged
      xfer(cw(REG_ROW, 1'b1, 16'h04B0), 24, 1'b1);
      chkState(2'h0, 4'h4, 11'h2AA);
      xfer(cw(REG_STATUS, 1'b0, 16'h0000), 24, 1'b1);
      chk("rowErr", 1'b1, rx[3]);
      // Interrupt held across short and deselected frames
      ovfEvent = 1'b1;
      eomEvent = 1'b1;
      @(posedge mclk);
      #1;
      ovfEvent = 1'b0;
      eomEvent = 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      chk("intPin", 1'b0, intPin);
      xfer(cw(REG_CFG, 1'b1, 16'h0003), 23, 1'b1);
      xfer(cw(REG_CFG, 1'b1, 16'h0003), 24, 1'b0);
      chkState(2'h0, 4'h4, 11'h2AA);
      chk("intOe", 1'b1, intOe);
      xfer(cw(REG_ROW, 1'b0, 16'h0000), 24, 1'b1);
      chk("statusIntErr", 2'h3, rx[3:2]);
      chk("statusFlags", 2'h3, rx[1:0]);
      chk("intOe", 1'b0, intOe);
      // Readback of the selected row, LSB first
      xfer(cw(REG_ROW, 1'b1, 16'h0155), 24, 1'b1);
      chk("rowRead", 11'h2AA, rx[18:8]);
      chkState(2'h0, 4'h4, 11'h155);
      // Clock enable low: an event is not taken
      ce = 1'b0;
      ovfEvent = 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      ovfEvent = 1'b0;
      ce = 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      chk("intOeFrozen", 1'b0, intOe);
      // Interrupt pending, then reset in mid-run
      ovfEvent = 1'b1;
      @(posedge mclk);
      #1;
      ovfEvent = 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      chk("intOe", 1'b1, intOe);
      rstn = 1'b0;
      repeat (4) @(posedge mclk);
      #1;
      rstn = 1'b1;
      pd = 8'h00;
      chkState(2'h0, 4'h4, 11'h000);
      chk("intOe", 1'b0, intOe);
      chk("misoOe", 1'b0, misoOe);
      repeat (3) @(posedge mclk);
      #1;
      // Port works again after the reset
      xfer(cw(REG_CFG, 1'b1, 16'h0002), 24, 1'b1);
      chkState(2'h2, 4'h6, 11'h000);
      results();
   end
endmodule : tb_top
`default_nettype wire
